// ==== src/cemc_ctrl.sv ====
// top: status codes, maintenance commands and parameter access arbitration
//
// Overview of operation
// - warning 00h normally, 84h on link error
// - warning 85h when receive cycle lacks frame
// - error 85h for non-communicating target axis
// - error 88h unsupported command, 00h on success
// - refuse master command with 89h during tool
// - error 8Ch for monitor axis out of range
// - error 8Dh when slave answers status set
// - six 8-bit maintenance objects, reset to zero
// - writing one to object runs its action
// - tool modes reject fieldbus parameter access, 89h
// - fieldbus parameter access or maintenance blocks tool access
// - fieldbus writes go to RAM only
// - power-up copies storage to RAM, then applies
`timescale 1ns/1ps
module cemc_ctrl (
   input  wire logic                         clk_i,
   input  wire logic                         rst_n_i,
   // fieldbus object access
   input  wire logic                         obj_wr_i,
   input  wire logic                         obj_rd_i,
   input  wire logic [15:0]                  obj_index_i,
   input  wire logic [7:0]                   obj_wdata_i,
   output logic                              obj_ack_o,
   output logic      [7:0]                   obj_rdata_o,
   output logic      [7:0]                   obj_err_o,
   // remote register / monitor requests
   input  wire logic                         request_strobe_i,
   input  wire logic                         req_kind_i,
   input  wire logic [cemc_pkg::AXIS_W-1:0]  req_axis_i,
   input  wire logic                         req_cmd_ok_i,
   input  wire logic [cemc_pkg::N_AXIS-1:0]  axis_comm_i,
   output logic                              fwd_strobe_o,
   output logic      [cemc_pkg::AXIS_W-1:0]  fwd_axis_o,
   input  wire logic                         slave_resp_i,
   input  wire logic                         slave_status_i,
   output logic                              resp_valid_o,
   output logic      [7:0]                   resp_err_o,
   // link status events
   input  wire logic                         link_err_i,
   input  wire logic                         frame_done_i,
   input  wire logic                         rx_cycle_end_i,
   output logic      [7:0]                   warn_code_o,
   // local tool port
   input  wire logic                         tool_mode_i,
   input  wire logic                         tool_req_i,
   input  wire logic                         tool_wr_i,
   input  wire logic [cemc_pkg::PARAM_AW-1:0] tool_addr_i,
   input  wire logic [7:0]                   tool_wdata_i,
   output logic                              tool_ack_o,
   output logic                              tool_refused_o,
   output logic      [7:0]                   tool_rdata_o,
   // maintenance effects
   output logic                              alarm_reset_o,
   output logic                              alarm_hist_clr_o,
   output logic                              setup_apply_o,
   output logic                              maint_busy_o
);
   import cemc_pkg::*;

   // ----------------
   // decoding shared by object access and arbitration
   // ----------------
   function automatic logic is_param(input logic [15:0] idx);
      is_param = (idx >= OBJ_PARAM_BASE) &&
                 (idx <  OBJ_PARAM_BASE + 16'(N_PARAM));
   endfunction

   function automatic logic [15:0] maint_index(input int unsigned slot);
      case (slot)
         M_ALARM_RESET: maint_index = OBJ_ALARM_RESET;
         M_ALARM_HIST:  maint_index = OBJ_ALARM_HIST_CLR;
         M_WARN_HIST:   maint_index = OBJ_WARN_HIST_CLR;
         M_NV_READ:     maint_index = OBJ_NV_BULK_READ;
         M_NV_WRITE:    maint_index = OBJ_NV_BULK_WRITE;
         default:       maint_index = OBJ_FULL_DATA_INIT;
      endcase
   endfunction

   logic [7:0]          param_ram [N_PARAM];   // working copy
   logic [7:0]          param_nv  [N_PARAM];   // non-volatile store
   cemc_state_t         state_q;
   logic [PARAM_AW-1:0] cnt_q;
   logic [N_MAINT-1:0]  hit;
   logic [N_MAINT-1:0]  start;
   logic [N_MAINT-1:0]  done;
   logic [7:0]          mval [N_MAINT];
   logic                obj_any;
   logic                obj_maint;
   logic                obj_param;
   logic                fb_param;
   logic                maint_run;
   logic [PARAM_AW-1:0] fb_addr;
   logic                last_cnt;
   logic                tool_go;

   assign obj_any   = obj_wr_i || obj_rd_i;
   assign obj_maint = |hit;
   assign obj_param = is_param(obj_index_i);
   assign fb_addr   = obj_index_i[PARAM_AW-1:0];
   assign maint_run = (state_q != ST_IDLE);
   assign last_cnt  = (cnt_q == PARAM_AW'(N_PARAM - 1));
   // fieldbus parameter access is taken only when tool and sequencer are idle
   assign fb_param  = obj_any && obj_param && !tool_mode_i && !maint_run;
   // fieldbus parameter access and any maintenance activity lock the tool out
   assign tool_go   = tool_req_i && !fb_param && !maint_run && !(|start);

   // ----------------
   // maintenance objects
   // ----------------
   genvar g;
   generate
      for (g = 0; g < N_MAINT; g++) begin : g_obj
         assign hit[g] = (obj_index_i == maint_index(g));
         cemc_maint_obj u_obj (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .wr_i    (obj_wr_i && hit[g] && !tool_mode_i),
            .wdata_i (obj_wdata_i),
            .done_i  (done[g]),
            .value_o (mval[g]),
            .start_o (start[g])
         );
      end
   endgenerate

   // single-cycle actions finish with their start; bulk ones when the sequencer ends
   always_comb begin
      done                = start;
      done[M_NV_READ]     = (state_q == ST_NV_TO_RAM) && last_cnt;
      done[M_NV_WRITE]    = (state_q == ST_RAM_TO_NV) && last_cnt;
      done[M_FULL_INIT]   = (state_q == ST_INIT_ALL) && last_cnt;
   end

   // ----------------
   // bulk sequencer: boot copy, bulk read, bulk write, full initialisation
   // ----------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_BOOT_COPY;
         cnt_q   <= '0;
      end else begin
         case (state_q)
            ST_BOOT_COPY: begin
               cnt_q <= cnt_q + 1'b1;
               if (last_cnt) begin
                  state_q <= ST_BOOT_APPLY;
               end
            end
            ST_BOOT_APPLY: begin
               state_q <= ST_IDLE;
            end
            ST_IDLE: begin
               cnt_q <= '0;
               // one bulk action at a time; a start that finds us busy is dropped
               if (start[M_FULL_INIT]) begin
                  state_q <= ST_INIT_ALL;
               end else if (start[M_NV_WRITE]) begin
                  state_q <= ST_RAM_TO_NV;
               end else if (start[M_NV_READ]) begin
                  state_q <= ST_NV_TO_RAM;
               end
            end
            ST_NV_TO_RAM,
            ST_RAM_TO_NV,
            ST_INIT_ALL: begin
               cnt_q <= cnt_q + 1'b1;
               if (last_cnt) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // working RAM: sequencer first, then fieldbus, then tool
   always_ff @(posedge clk_i) begin
      if (state_q == ST_BOOT_COPY || state_q == ST_NV_TO_RAM) begin
         param_ram[cnt_q] <= param_nv[cnt_q];
      end else if (state_q == ST_INIT_ALL) begin
         param_ram[cnt_q] <= PARAM_INIT_VAL;
      end else if (fb_param && obj_wr_i) begin
         param_ram[fb_addr] <= obj_wdata_i;
      end else if (tool_go && tool_wr_i) begin
         param_ram[tool_addr_i] <= tool_wdata_i;
      end
   end

   // storage is touched only by bulk write and full initialisation
   always_ff @(posedge clk_i) begin
      if (state_q == ST_RAM_TO_NV) begin
         param_nv[cnt_q] <= param_ram[cnt_q];
      end else if (state_q == ST_INIT_ALL) begin
         param_nv[cnt_q] <= PARAM_INIT_VAL;
      end
   end

   // ----------------
   // fieldbus object answer
   // ----------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         obj_ack_o   <= 1'b0;
         obj_rdata_o <= 8'h00;
         obj_err_o   <= CERR_NONE;
      end else begin
         obj_ack_o   <= obj_any;
         obj_rdata_o <= 8'h00;
         obj_err_o   <= CERR_NONE;
         if (obj_any) begin
            if (tool_mode_i && (obj_param || obj_maint)) begin
               obj_err_o <= CERR_TOOL_BUSY;
            end else if (obj_param && maint_run) begin
               obj_err_o <= CERR_TOOL_BUSY;
            end else if (obj_param) begin
               obj_rdata_o <= param_ram[fb_addr];
            end else if (obj_maint) begin
               for (int i = 0; i < N_MAINT; i++) begin
                  if (hit[i]) begin
                     obj_rdata_o <= mval[i];
                  end
               end
            end else begin
               obj_err_o <= CERR_UNDEF_CMD;                         // unmapped index
            end
         end
      end
   end

   // ----------------
   // remote register / monitor requests
   // ----------------
   logic pend_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_q       <= 1'b0;
         fwd_strobe_o <= 1'b0;
         fwd_axis_o   <= '0;
         resp_valid_o <= 1'b0;
         resp_err_o   <= CERR_NONE;
      end else begin
         fwd_strobe_o <= 1'b0;
         resp_valid_o <= 1'b0;
         if (pend_q) begin
            // a strobe while a slave answer is outstanding is ignored
            if (slave_resp_i) begin
               pend_q       <= 1'b0;
               resp_valid_o <= 1'b1;
               resp_err_o   <= slave_status_i ? CERR_EXEC_DIS : CERR_NONE;
            end
         end else if (request_strobe_i) begin
            resp_valid_o <= 1'b1;
            if (tool_mode_i) begin
               resp_err_o <= CERR_TOOL_BUSY;
            end else if (req_kind_i == REQ_MONITOR && req_axis_i > AXIS_MAX) begin
               resp_err_o <= CERR_RANGE;
            end else if (req_axis_i > AXIS_MAX || !axis_comm_i[req_axis_i[3:0]]) begin
               resp_err_o <= CERR_TIMEOUT;
            end else if (!req_cmd_ok_i) begin
               resp_err_o <= CERR_UNDEF_CMD;
            end else begin
               resp_valid_o <= 1'b0;
               pend_q       <= 1'b1;
               fwd_strobe_o <= 1'b1;
               fwd_axis_o   <= req_axis_i;
            end
         end
      end
   end

   // ----------------
   // warning code; an event in the clearing cycle wins
   // ----------------
   logic frame_seen_q;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frame_seen_q <= 1'b0;
         warn_code_o  <= WARN_NONE;
      end else begin
         if (rx_cycle_end_i) begin
            frame_seen_q <= 1'b0;
         end else if (frame_done_i) begin
            frame_seen_q <= 1'b1;
         end
         if (link_err_i) begin
            warn_code_o <= WARN_LINK_ERR;
         end else if (rx_cycle_end_i && !frame_seen_q && !frame_done_i) begin
            warn_code_o <= WARN_TIMEOUT;
         end else if (start[M_WARN_HIST]) begin
            warn_code_o <= WARN_NONE;
         end
      end
   end

   // ----------------
   // tool port and maintenance effect outputs
   // ----------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tool_ack_o       <= 1'b0;
         tool_refused_o   <= 1'b0;
         tool_rdata_o     <= 8'h00;
         alarm_reset_o    <= 1'b0;
         alarm_hist_clr_o <= 1'b0;
         setup_apply_o    <= 1'b0;
         maint_busy_o     <= 1'b1;
      end else begin
         tool_ack_o       <= tool_go;
         tool_refused_o   <= tool_req_i && !tool_go;
         tool_rdata_o     <= tool_go ? param_ram[tool_addr_i] : 8'h00;
         alarm_reset_o    <= start[M_ALARM_RESET];
         alarm_hist_clr_o <= start[M_ALARM_HIST];
         setup_apply_o    <= (state_q == ST_BOOT_APPLY);
         maint_busy_o     <= maint_run || (|start);
      end
   end

endmodule

// ==== src/cemc_pkg.sv ====
// package: constants, object map and codes of the block
package cemc_pkg;

   // ----------------
   // object map
   // ----------------
   localparam logic [15:0] OBJ_ALARM_RESET     = 16'h3e80;
   localparam logic [15:0] OBJ_ALARM_HIST_CLR  = 16'h3e81;
   localparam logic [15:0] OBJ_WARN_HIST_CLR   = 16'h3e82;
   localparam logic [15:0] OBJ_NV_BULK_READ    = 16'h3e84;
   localparam logic [15:0] OBJ_NV_BULK_WRITE   = 16'h3e85;
   localparam logic [15:0] OBJ_FULL_DATA_INIT  = 16'h3e86;
   localparam logic [15:0] OBJ_PARAM_BASE      = 16'h4000;

   // ----------------
   // sizes
   // ----------------
   localparam int unsigned N_MAINT   = 6;
   localparam int unsigned PARAM_AW  = 4;
   localparam int unsigned N_PARAM   = 16;
   localparam int unsigned AXIS_W    = 8;
   localparam int unsigned N_AXIS    = 16;
   localparam logic [7:0]  AXIS_MAX  = 8'h0f;

   // maintenance object slots
   localparam int unsigned M_ALARM_RESET = 0;
   localparam int unsigned M_ALARM_HIST  = 1;
   localparam int unsigned M_WARN_HIST   = 2;
   localparam int unsigned M_NV_READ     = 3;
   localparam int unsigned M_NV_WRITE    = 4;
   localparam int unsigned M_FULL_INIT   = 5;

   // ----------------
   // values and codes
   // ----------------
   localparam logic [7:0] OBJ_RESET_VAL   = 8'h00;
   localparam logic [7:0] OBJ_TRIGGER_VAL = 8'h01;
   localparam logic [7:0] PARAM_INIT_VAL  = 8'h00;

   localparam logic [7:0] WARN_NONE       = 8'h00;
   localparam logic [7:0] WARN_LINK_ERR   = 8'h84;
   localparam logic [7:0] WARN_TIMEOUT    = 8'h85;

   localparam logic [7:0] CERR_NONE       = 8'h00;
   localparam logic [7:0] CERR_TIMEOUT    = 8'h85;
   localparam logic [7:0] CERR_UNDEF_CMD  = 8'h88;
   localparam logic [7:0] CERR_TOOL_BUSY  = 8'h89;
   localparam logic [7:0] CERR_RANGE      = 8'h8c;
   localparam logic [7:0] CERR_EXEC_DIS   = 8'h8d;

   // request kinds on the remote request port
   localparam logic REQ_REGISTER = 1'b0;
   localparam logic REQ_MONITOR  = 1'b1;

   // maintenance sequencer states
   typedef enum logic [2:0] {
      ST_BOOT_COPY,
      ST_BOOT_APPLY,
      ST_IDLE,
      ST_NV_TO_RAM,
      ST_RAM_TO_NV,
      ST_INIT_ALL
   } cemc_state_t;

endpackage

// ==== src/cemc_maint_obj.sv ====
// one 8-bit one-shot maintenance object
`timescale 1ns/1ps
module cemc_maint_obj (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       wr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       done_i,
   output logic      [7:0] value_o,
   output logic            start_o
);
   import cemc_pkg::*;

   logic [7:0] value_q;
   logic       start_q;

   // ----------------
   // stored value, returned to zero when the action has completed
   // ----------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_q <= OBJ_RESET_VAL;
      end else if (wr_i) begin
         value_q <= wdata_i;                            // a new write beats the clear
      end else if (done_i) begin
         value_q <= OBJ_RESET_VAL;
      end
   end

   // one-cycle start on a write of the trigger value
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_q <= 1'b0;
      end else begin
         start_q <= wr_i && (wdata_i == OBJ_TRIGGER_VAL);
      end
   end

   assign value_o = value_q;
   assign start_o = start_q;
endmodule

// ==== tb/cemc_ctrl_asserts.sv ====
// checker: timed properties on the ports of cemc_ctrl
`timescale 1ns/1ps
module cemc_ctrl_asserts (
   input logic        clk_i,
   input logic        rst_n_i,
   input logic        obj_wr_i,
   input logic        obj_rd_i,
   input logic [15:0] obj_index_i,
   input logic [7:0]  obj_err_o,
   input logic        request_strobe_i,
   input logic        req_kind_i,
   input logic [7:0]  req_axis_i,
   input logic [15:0] axis_comm_i,
   input logic        fwd_strobe_o,
   input logic        slave_resp_i,
   input logic        slave_status_i,
   input logic        resp_valid_o,
   input logic [7:0]  resp_err_o,
   input logic        link_err_i,
   input logic        frame_done_i,
   input logic        rx_cycle_end_i,
   input logic [7:0]  warn_code_o,
   input logic        tool_mode_i,
   input logic        tool_req_i,
   input logic        tool_ack_o,
   input logic        tool_refused_o,
   input logic        maint_busy_o
);
   import cemc_pkg::*;
   logic pend_q;
   logic seen_q;
   logic armed_q;
   // decoded access kinds; 3e83 and 3e87 are holes in the object map
   wire acc  = obj_wr_i || obj_rd_i;
   wire prm  = obj_index_i[15:4] == OBJ_PARAM_BASE[15:4];
   wire mnt  = obj_index_i[15:3] == 13'h07d0 && obj_index_i[1:0] != 2'd3;
   wire free = !pend_q && !fwd_strobe_o && !resp_valid_o;
   // a forwarded request stays open until its answer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) pend_q <= 1'b0;
      else if (fwd_strobe_o) pend_q <= 1'b1;
      else if (resp_valid_o) pend_q <= 1'b0;
   end
   // frame seen in the current receive cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) seen_q <= 1'b0;
      else if (rx_cycle_end_i) seen_q <= 1'b0;
      else if (frame_done_i) seen_q <= 1'b1;
   end
   // the first receive cycle has no known start, so it is not judged
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) armed_q <= 1'b0;
      else armed_q <= armed_q || rx_cycle_end_i;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   sequence s_req;
      request_strobe_i && free && !tool_mode_i;
   endsequence
   sequence s_ans(logic [7:0] c);
      resp_valid_o && resp_err_o == c;
   endsequence
   a_link_warn: assert property (link_err_i |=> warn_code_o == WARN_LINK_ERR)
      else $error("link error not reported");
   a_timeout_warn: assert property (
      rx_cycle_end_i && !frame_done_i && !seen_q && armed_q && !link_err_i
      |=> warn_code_o == WARN_TIMEOUT) else $error("missing frame not reported");
   a_dead_axis: assert property (
      s_req ##0 (req_axis_i <= AXIS_MAX && !axis_comm_i[req_axis_i[3:0]])
      |=> s_ans(CERR_TIMEOUT)) else $error("silent axis not refused");
   a_undef_index: assert property (acc && !prm && !mnt |=> obj_err_o == CERR_UNDEF_CMD)
      else $error("unmapped index not refused");
   a_mon_range: assert property (
      s_req ##0 (req_kind_i && req_axis_i > AXIS_MAX) |=> s_ans(CERR_RANGE))
      else $error("monitor axis range not refused");
   a_slave_answer: assert property (
      pend_q && slave_resp_i
      |=> s_ans($past(slave_status_i) ? CERR_EXEC_DIS : CERR_NONE))
      else $error("slave answer code wrong");
   a_tool_param: assert property (acc && prm && tool_mode_i |=> obj_err_o == CERR_TOOL_BUSY)
      else $error("tool mode access not refused");
   a_tool_blocked: assert property (
      tool_req_i ##1 (maint_busy_o || $past(acc && prm && !tool_mode_i))
      |-> tool_refused_o && !tool_ack_o) else $error("tool access not blocked");
endmodule

// ==== tb/cemc_slave_model.sv ====
// partner: rs-485 slave axis answering forwarded requests
`timescale 1ns/1ps
module cemc_slave_model (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       fwd_strobe_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       status_i,
   output logic            slave_resp_o,
   output logic            slave_status_o
);
   logic [3:0] wait_q;
   logic       busy_q;
   // answer delay_i+2 cycles after the forward; status churns between answers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q         <= 1'b0;
         wait_q         <= 4'h0;
         slave_resp_o   <= 1'b0;
         slave_status_o <= 1'b0;
      end else begin
         slave_resp_o   <= 1'b0;
         slave_status_o <= ~slave_status_o;
         if (fwd_strobe_i) begin
            busy_q <= 1'b1;
            wait_q <= delay_i;
         end else if (busy_q && wait_q == 4'h0) begin
            busy_q         <= 1'b0;
            slave_resp_o   <= 1'b1;
            slave_status_o <= status_i;
         end else if (busy_q) begin
            wait_q <= wait_q - 4'h1;
         end
      end
   end
endmodule

// ==== tb/test_cemc_ctrl.sv ====
// testbench: objects, requests, link events and tool port of cemc_ctrl
`timescale 1ns/1ps
module test_cemc_ctrl;
   import cemc_pkg::*;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, obj_wr_i = 1'b0, obj_rd_i = 1'b0;
   logic        request_strobe_i = 1'b0, req_kind_i = 1'b0, req_cmd_ok_i = 1'b0;
   logic        link_err_i = 1'b0, frame_done_i = 1'b0, rx_cycle_end_i = 1'b0;
   logic        tool_mode_i = 1'b0, tool_req_i = 1'b0, tool_wr_i = 1'b0, slv_st = 1'b0;
   logic [15:0] obj_index_i = '0, axis_comm_i = '0;
   logic [7:0]  obj_wdata_i = '0, req_axis_i = '0, tool_wdata_i = '0;
   logic [3:0]  tool_addr_i = '0, slv_dly = '0;
   logic        obj_ack_o, fwd_strobe_o, resp_valid_o, slave_resp_i, slave_status_i;
   logic        tool_ack_o, tool_refused_o, alarm_reset_o, alarm_hist_clr_o;
   logic        setup_apply_o, maint_busy_o;
   logic [7:0]  obj_rdata_o, obj_err_o, fwd_axis_o, resp_err_o, warn_code_o, tool_rdata_o;
   logic [7:0]  ram_m [16];
   logic [7:0]  nv_m [16];
   logic [15:0] mobj [6] = '{OBJ_ALARM_RESET, OBJ_ALARM_HIST_CLR, OBJ_WARN_HIST_CLR,
                             OBJ_NV_BULK_READ, OBJ_NV_BULK_WRITE, OBJ_FULL_DATA_INIT};
   int          fail_count = 0, checked = 0, applies = 0, alarms = 0, clears = 0;
   cemc_ctrl i_cemc_ctrl (.*);
   cemc_slave_model i_cemc_slave_model (.clk_i, .rst_n_i, .fwd_strobe_i(fwd_strobe_o),
      .delay_i(slv_dly), .status_i(slv_st), .slave_resp_o(slave_resp_i),
      .slave_status_o(slave_status_i));
   always #12.5 clk_i = ~clk_i;
   // effect pulses are counted so a doubled or missing pulse shows
   always @(negedge clk_i) begin
      applies += int'(setup_apply_o === 1'b1);
      alarms  += int'(alarm_reset_o === 1'b1);
      clears  += int'(alarm_hist_clr_o === 1'b1);
   end
   task complete_run;
      if (fail_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task cmp_code(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      cmp_code({7'h0, got}, {7'h0, exp});
   endtask
   task fail_wait;
      fail_count++;
      $display("mismatch at %0t: wait ran out", $time);
      complete_run();
   endtask
   task wait_idle;
      for (int n = 0; maint_busy_o !== 1'b0; n++) begin
         if (n > 100) fail_wait();
         @(negedge clk_i);
      end
   endtask
   task obj_acc(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                input logic [7:0] e_err, input logic [7:0] e_rd);
      @(posedge clk_i);
      obj_wr_i    <= wr;
      obj_rd_i    <= !wr;
      obj_index_i <= idx;
      obj_wdata_i <= wd;
      @(posedge clk_i);
      obj_wr_i <= 1'b0;
      obj_rd_i <= 1'b0;
      @(negedge clk_i);
      cmp_bit(obj_ack_o, 1'b1);
      cmp_code(obj_err_o, e_err);
      if (!wr && e_err === CERR_NONE) cmp_code(obj_rdata_o, e_rd);
   endtask
   task tool_acc(input logic wr, input logic [3:0] a, input logic [7:0] wd,
                 input logic ok, input logic [7:0] e_rd);
      @(posedge clk_i);
      tool_req_i   <= 1'b1;
      tool_wr_i    <= wr;
      tool_addr_i  <= a;
      tool_wdata_i <= wd;
      @(posedge clk_i);
      tool_req_i <= 1'b0;
      @(negedge clk_i);
      cmp_bit(tool_ack_o, ok);
      cmp_bit(tool_refused_o, !ok);
      if (ok && !wr) cmp_code(tool_rdata_o, e_rd);
   endtask
   // trigger an object, wait out its action, then it must read zero again
   task maint(input logic [15:0] idx);
      obj_acc(1'b1, idx, OBJ_TRIGGER_VAL, CERR_NONE, 8'h00);
      @(negedge clk_i);
      wait_idle();
      obj_acc(1'b0, idx, 8'h00, CERR_NONE, OBJ_RESET_VAL);
   endtask
   task check_ram;
      for (int i = 0; i < 16; i++) begin
         obj_acc(1'b0, OBJ_PARAM_BASE + 16'(i), 8'h00, CERR_NONE, ram_m[i]);
         tool_acc(1'b0, 4'(i), 8'h00, 1'b1, ram_m[i]);
      end
   endtask
   task ev(input logic le, input logic fd, input logic ce, input logic [7:0] e_w);
      @(posedge clk_i);
      link_err_i     <= le;
      frame_done_i   <= fd;
      rx_cycle_end_i <= ce;
      @(posedge clk_i);
      link_err_i     <= 1'b0;
      frame_done_i   <= 1'b0;
      rx_cycle_end_i <= 1'b0;
      @(negedge clk_i);
      cmp_code(warn_code_o, e_w);
   endtask
   task automatic req(input logic kind, input logic [7:0] ax, input logic ok,
                      input logic st, input logic [7:0] e_err, input logic e_fwd);
      logic fwd = 1'b0;
      @(posedge clk_i);
      request_strobe_i <= 1'b1;
      req_kind_i       <= kind;
      req_axis_i       <= ax;
      req_cmd_ok_i     <= ok;
      slv_st           <= st;
      slv_dly          <= 4'($urandom);
      @(posedge clk_i);
      request_strobe_i <= 1'b0;
      for (int n = 0; resp_valid_o !== 1'b1; n++) begin
         @(negedge clk_i);
         fwd |= (fwd_strobe_o === 1'b1);
         if (n > 40) fail_wait();
      end
      cmp_bit(fwd, e_fwd);
      if (fwd) cmp_code(fwd_axis_o, ax);
      cmp_code(resp_err_o, e_err);
      @(negedge clk_i);
      cmp_bit(resp_valid_o, 1'b0);
   endtask
   initial begin
      logic [3:0]  a;
      logic [7:0]  d;
      logic [15:0] c;
      void'($urandom(32'h3c82));
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (mobj[i]) obj_acc(1'b0, mobj[i], 8'h00, CERR_NONE, OBJ_RESET_VAL);
      cmp_code(warn_code_o, WARN_NONE);
      wait_idle();
      cmp_code(8'(applies), 8'd1);
      maint(OBJ_FULL_DATA_INIT);
      foreach (ram_m[i]) ram_m[i] = 8'h00;
      foreach (nv_m[i]) nv_m[i] = 8'h00;
      for (int i = 0; i < 4; i++) begin
         a = 4'($urandom);
         d = 8'($urandom);
         ram_m[a] = d;
         obj_acc(1'b1, OBJ_PARAM_BASE + 16'(a), d, CERR_NONE, 8'h00);
      end
      tool_acc(1'b1, a + 4'd1, 8'hc3, 1'b1, 8'h00);
      ram_m[a + 4'd1] = 8'hc3;
      check_ram();
      // a bulk read must wipe the unsaved writes
      maint(OBJ_NV_BULK_READ);
      ram_m = nv_m;
      check_ram();
      obj_acc(1'b1, OBJ_PARAM_BASE + 16'(a), d, CERR_NONE, 8'h00);
      ram_m[a] = d;
      obj_acc(1'b1, OBJ_NV_BULK_WRITE, OBJ_TRIGGER_VAL, CERR_NONE, 8'h00);
      tool_acc(1'b0, a, 8'h00, 1'b0, 8'h00);
      wait_idle();
      obj_acc(1'b0, OBJ_NV_BULK_WRITE, 8'h00, CERR_NONE, OBJ_RESET_VAL);
      nv_m = ram_m;
      obj_acc(1'b1, OBJ_PARAM_BASE + 16'(a), ~d, CERR_NONE, 8'h00);
      maint(OBJ_NV_BULK_READ);
      check_ram();
      obj_acc(1'b1, OBJ_ALARM_RESET, 8'h05, CERR_NONE, 8'h00);
      obj_acc(1'b0, OBJ_ALARM_RESET, 8'h00, CERR_NONE, 8'h05);
      maint(OBJ_ALARM_RESET);
      maint(OBJ_ALARM_HIST_CLR);
      cmp_code(8'(alarms), 8'd1);
      cmp_code(8'(clears), 8'd1);
      ev(1'b0, 1'b1, 1'b0, WARN_NONE);
      ev(1'b0, 1'b0, 1'b1, WARN_NONE);
      ev(1'b0, 1'b0, 1'b1, WARN_TIMEOUT);
      ev(1'b1, 1'b0, 1'b0, WARN_LINK_ERR);
      ev(1'b0, 1'b1, 1'b1, WARN_LINK_ERR);
      maint(OBJ_WARN_HIST_CLR);
      cmp_code(warn_code_o, WARN_NONE);
      obj_acc(1'b0, 16'h3e83, 8'h00, CERR_UNDEF_CMD, 8'h00);
      obj_acc(1'b1, 16'h4010, 8'h11, CERR_UNDEF_CMD, 8'h00);
      c = 16'($urandom);
      c[2] = 1'b1;
      c[9] = 1'b0;
      @(posedge clk_i);
      axis_comm_i <= c;
      tool_mode_i <= 1'b1;
      obj_acc(1'b0, OBJ_PARAM_BASE, 8'h00, CERR_TOOL_BUSY, 8'h00);
      obj_acc(1'b1, OBJ_PARAM_BASE + 16'(a), 8'h5a, CERR_TOOL_BUSY, 8'h00);
      req(1'b0, 8'd2, 1'b1, 1'b0, CERR_TOOL_BUSY, 1'b0);
      @(posedge clk_i) tool_mode_i <= 1'b0;
      obj_acc(1'b0, OBJ_PARAM_BASE + 16'(a), 8'h00, CERR_NONE, ram_m[a]);
      req(1'b1, 8'h10, 1'b1, 1'b0, CERR_RANGE, 1'b0);
      req(1'b0, 8'h10, 1'b1, 1'b0, CERR_TIMEOUT, 1'b0);
      req(1'b0, 8'd9, 1'b1, 1'b0, CERR_TIMEOUT, 1'b0);
      req(1'b1, 8'd9, 1'b1, 1'b0, CERR_TIMEOUT, 1'b0);
      req(1'b0, 8'd2, 1'b0, 1'b0, CERR_UNDEF_CMD, 1'b0);
      req(1'b0, 8'd2, 1'b1, 1'b0, CERR_NONE, 1'b1);
      req(1'b1, 8'd2, 1'b1, 1'b1, CERR_EXEC_DIS, 1'b1);
      complete_run();
   end
endmodule
bind cemc_ctrl cemc_ctrl_asserts i_cemc_ctrl_asserts (.*);
